// *** logic/drc_consts.svh ***
// Purpose: Timing and geometry constants for the strobe controller
// Assumes: 20 MHz clock, 50 ns period
// Notes:   Cycle counts derive from the times in ns
`ifndef DRC_CONSTS_SVH
`define DRC_CONSTS_SVH
`define DRC_CLK_NS        50
`define DRC_T_RAC_NS      250
`define DRC_T_CAC_NS      165
`define DRC_T_RP_NS       150
`define DRC_T_RAS_NS      250
`define DRC_T_RCD_NS      100
`define DRC_T_WP_NS       75
`define DRC_T_CWD_NS      125
`define DRC_T_REF_MS      2
`define DRC_CYC_UP(t)     (((t) + `DRC_CLK_NS - 1) / `DRC_CLK_NS)
`define DRC_REF_PERIOD    ((`DRC_T_REF_MS * 1000000) / `DRC_CLK_NS)
`define DRC_ROWS          128
`define DRC_INIT_CYCLES   8
`endif

// *** logic/drc_pkg.sv ***
// Purpose: Types for the strobe controller
// Assumes: Constants header supplies the figures
// Notes:   One-hot state codes
package drc_pkg;
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_ROW  = 8'h02,
		ST_RCD  = 8'h04,
		ST_COL  = 8'h08,
		ST_WR   = 8'h10,
		ST_DONE = 8'h20,
		ST_PRE  = 8'h40,
		ST_REF  = 8'h80
	} drc_state_t;
	typedef enum logic [1:0] {
		OP_READ  = 2'h0,
		OP_EWR   = 2'h1,
		OP_RMW   = 2'h2
	} drc_op_t;
endpackage : drc_pkg

// *** logic/drc_tick_if.sv ***
// Purpose: Refresh request carrier between timer and sequencer
// Assumes: Single clock
// Notes:   Request held until acknowledged
`timescale 1ns/1ps
interface drc_tick_if;
	logic       req;
	logic       ack;
	logic [6:0] row;
	modport timer (output req, output row, input ack);
	modport seq   (input req, input row, output ack);
endinterface : drc_tick_if

// *** logic/drc_refresh_timer.sv ***
// Purpose: Paces refresh rows so all rows cycle within retention
// Assumes: Synchronous active-high reset
// Notes:   Period is a parameter so simulation may shorten it
`timescale 1ns/1ps
`include "drc_consts.svh"
module drc_refresh_timer import drc_pkg::*; #(
	parameter int REF_CYCLES = `DRC_REF_PERIOD
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// Request to sequencer
	drc_tick_if.timer tick
);
	localparam int INTERVAL = REF_CYCLES / `DRC_ROWS;
	logic [31:0] cnt_r;
	logic [6:0]  row_r;
	logic        req_r;
	assign tick.req = req_r;
	assign tick.row = row_r;
	always_ff @(posedge clock) begin
		if (rst) begin
			cnt_r <= 32'h0;
		end else if (cnt_r >= 32'(INTERVAL - 1)) begin
			cnt_r <= 32'h0;
		end else begin
			cnt_r <= cnt_r + 32'h1;
		end
	end
	// Seven-bit row counter advanced per served refresh
	always_ff @(posedge clock) begin
		if (rst) begin
			row_r <= 7'h0;
		end else if (tick.ack) begin
			row_r <= row_r + 7'h1; // see (RL18)
		end
	end
	// Set wins over acknowledge
	always_ff @(posedge clock) begin
		if (rst) begin
			req_r <= 1'b0;
		end else if (cnt_r >= 32'(INTERVAL - 1)) begin
			req_r <= 1'b1; // see (RL13)
		end else if (tick.ack) begin
			req_r <= 1'b0;
		end
	end
	property p_req_holds;
		@(posedge clock) disable iff (rst)
		req_r && !tick.ack |=> req_r;
	endproperty
	a_req_holds: assert property (p_req_holds) else $error("refresh request dropped"); // see (RL18)
	property p_row_steps;
		@(posedge clock) disable iff (rst)
		tick.ack |=> row_r == $past(row_r) + 7'h1;
	endproperty
	a_row_steps: assert property (p_row_steps) else $error("row counter not advanced"); // see (RL14)
endmodule : drc_refresh_timer

// *** logic/drc_ctrl.sv ***
// Purpose: Host controller driving a 16K x 1 multiplexed-strobe DRAM
// Assumes: Pins are synchronous to clock; one access at a time
// Notes:   Refresh has priority over a waiting access
`timescale 1ns/1ps
`include "drc_consts.svh"
// Overview of operation
// (RL1) Fourteen address bits: seven row, seven column
// (RL2) Address stable before each strobe falls
// (RL3) Row strobe opens row; column strobe selects
// (RL4) Write select high reads, low writes
// (RL5) Data-in ignored by device on reads
// (RL6) Early write keeps output floating
// (RL7) Early write data taken at column fall
// (RL8) Late write data taken at write fall
// (RL9) Output floats until column strobe low
// (RL10) Read data valid after both access delays
// (RL11) Read data has written polarity
// (RL12) Late write output follows read sequence
// (RL13) Whole array refreshed within two milliseconds
// (RL14) Row-only refresh over 128 rows
// (RL15) Output unlatched; sample while column low
// (RL16) Page mode keeps row, strobes columns
// (RL17) Eight row cycles after power-up
// (RL18) Row counter, refresh arbitrated against access
module drc_ctrl import drc_pkg::*; #(
	parameter int REF_CYCLES = `DRC_REF_PERIOD
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// User request
	input  wire logic        req_valid,
	input  wire logic [13:0] req_addr,
	input  wire logic [1:0]  req_op,
	input  wire logic        req_wdata,
	input  wire logic        req_page,
	output logic             req_ready,
	output logic             rsp_valid,
	output logic             rsp_rdata,
	output logic             init_done,
	// DRAM pins
	output logic             row_strobe_n,
	output logic             column_strobe_n,
	output logic             store_select_n,
	output logic [6:0]       multiplexed_lines,
	output logic             input_bit,
	input  wire logic        output_bit
);
	localparam logic [3:0] RP_C  = 4'(`DRC_CYC_UP(`DRC_T_RP_NS));
	localparam logic [3:0] RCD_C = 4'(`DRC_CYC_UP(`DRC_T_RCD_NS));
	localparam logic [3:0] RAS_C = 4'(`DRC_CYC_UP(`DRC_T_RAS_NS));
	localparam logic [3:0] CAC_C = 4'(`DRC_CYC_UP(`DRC_T_CAC_NS));
	localparam logic [3:0] CWD_C = 4'(`DRC_CYC_UP(`DRC_T_CWD_NS));
	localparam logic [3:0] WP_C  = 4'(`DRC_CYC_UP(`DRC_T_WP_NS));
	localparam logic [3:0] INIT_C = 4'(`DRC_INIT_CYCLES);

	drc_tick_if tick ();
	drc_refresh_timer #(.REF_CYCLES(REF_CYCLES)) u_timer (
		.clock (clock),
		.rst   (rst),
		.tick  (tick.timer)
	);

	drc_state_t  state_r;
	logic [3:0]  cnt_r;
	logic [3:0]  init_r;
	logic [13:0] addr_r;
	logic [1:0]  op_r;
	logic        wdata_r;
	logic        page_r;
	logic        ack_r;
	logic        rd_r;

	assign tick.ack = ack_r;

	function automatic logic [6:0] row_of(input logic [13:0] a);
		row_of = a[13:7];
	endfunction : row_of

	function automatic logic [6:0] col_of(input logic [13:0] a);
		col_of = a[6:0];
	endfunction : col_of

	wire take = (state_r == ST_IDLE || (state_r == ST_DONE && page_r)) && init_done
		&& !tick.req && req_valid;
	wire same_row = page_r && row_of(req_addr) == row_of(addr_r); // see (RL16)

	// Sequencer
	always_ff @(posedge clock) begin
		if (rst) begin
			state_r <= ST_IDLE;
			cnt_r   <= 4'h0;
			ack_r   <= 1'b0;
			addr_r  <= 14'h0;
			op_r    <= 2'h0;
			wdata_r <= 1'b0;
			page_r  <= 1'b0;
		end else begin
			ack_r <= 1'b0;
			cnt_r <= (cnt_r != 4'h0) ? cnt_r - 4'h1 : 4'h0;
			case (state_r)
			ST_IDLE: begin
				// Ready is a promise: a request seen with it beats refresh
				if (req_valid && req_ready) begin
					addr_r  <= req_addr;
					op_r    <= req_op;
					wdata_r <= req_wdata;
					page_r  <= req_page;
					state_r <= ST_ROW;
					cnt_r   <= RCD_C;
				end else if (!init_done || tick.req) begin
					state_r <= ST_REF; // see (RL17)
					cnt_r   <= RAS_C;
				end
			end
			ST_ROW: begin
				if (cnt_r == 4'h0) begin
					state_r <= ST_COL;
					cnt_r   <= (op_r == OP_RMW) ? CWD_C : CAC_C;
				end
			end
			ST_COL: begin
				if (cnt_r == 4'h0) begin
					state_r <= (op_r == OP_READ) ? ST_DONE : ST_WR;
					cnt_r   <= WP_C;
				end
			end
			ST_WR: begin
				if (cnt_r == 4'h0) begin
					state_r <= ST_DONE;
				end
			end
			ST_DONE: begin
				if (take && same_row) begin
					addr_r  <= req_addr;
					op_r    <= req_op;
					wdata_r <= req_wdata;
					page_r  <= req_page;
					state_r <= ST_RCD;
					cnt_r   <= RP_C;
				end else begin
					state_r <= ST_PRE;
					cnt_r   <= RP_C;
				end
			end
			ST_RCD: begin
				// Column precharge inside open page
				if (cnt_r == 4'h0) begin
					state_r <= ST_COL;
					cnt_r   <= (op_r == OP_RMW) ? CWD_C : CAC_C;
				end
			end
			ST_REF: begin
				if (cnt_r == 4'h0) begin
					state_r <= ST_PRE;
					cnt_r   <= RP_C;
					ack_r   <= init_done;
				end
			end
			ST_PRE: begin
				if (cnt_r == 4'h0) begin
					state_r <= ST_IDLE;
				end
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Power-up row cycles
	always_ff @(posedge clock) begin
		if (rst) begin
			init_r    <= 4'h0;
			init_done <= 1'b0;
		end else if (state_r == ST_REF && cnt_r == 4'h0 && !init_done) begin
			init_r    <= init_r + 4'h1;
			init_done <= (init_r + 4'h1) == INIT_C; // see (RL17)
		end
	end

	// Strobes and address
	always_ff @(posedge clock) begin
		if (rst) begin
			row_strobe_n      <= 1'b1;
			column_strobe_n   <= 1'b1;
			store_select_n    <= 1'b1;
			multiplexed_lines <= 7'h0;
			input_bit         <= 1'b0;
		end else begin
			// Row held open in the page-hold cycle
			row_strobe_n <= !(state_r == ST_ROW || state_r == ST_COL || state_r == ST_WR
				|| state_r == ST_RCD || state_r == ST_REF
				|| (state_r == ST_DONE && page_r)); // see (RL3) (RL16)
			column_strobe_n <= !(state_r == ST_COL || state_r == ST_WR); // see (RL14)
			// Early write: select falls ahead of column strobe
			store_select_n <= !((op_r == OP_EWR && (state_r == ST_ROW || state_r == ST_RCD
				|| state_r == ST_COL)) || state_r == ST_WR); // see (RL4) (RL6) (RL8)
			if (state_r == ST_REF) begin
				multiplexed_lines <= tick.row; // see (RL14)
			end else if (state_r == ST_IDLE) begin
				// Refresh row unless a request is taken now
				multiplexed_lines <= (req_valid && req_ready) ? row_of(req_addr)
					: tick.row; // see (RL1) (RL2) (RL14)
			end else if (state_r == ST_ROW || state_r == ST_RCD) begin
				multiplexed_lines <= col_of(addr_r); // see (RL2)
			end
			input_bit <= wdata_r; // see (RL7) (RL5)
		end
	end

	// Read sampling at end of access; output is unlatched in the device
	always_ff @(posedge clock) begin
		if (rst) begin
			rd_r      <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= 1'b0;
		end else begin
			rd_r      <= state_r == ST_COL && cnt_r == 4'h0 && op_r != OP_EWR;
			rsp_valid <= rd_r; // see (RL10) (RL12)
			if (rd_r) begin
				rsp_rdata <= output_bit; // see (RL11) (RL15) (RL9)
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			req_ready <= 1'b0;
		end else begin
			// Dropped after a take so it is never stale
			req_ready <= state_r == ST_IDLE && init_done && !tick.req
				&& !(req_valid && req_ready); // see (RL18)
		end
	end

	property p_ref_no_cas;
		@(posedge clock) disable iff (rst)
		state_r == ST_REF |=> column_strobe_n;
	endproperty
	a_ref_no_cas: assert property (p_ref_no_cas) else $error("column strobe during refresh"); // see (RL14)
	property p_cas_after_ras;
		@(posedge clock) disable iff (rst)
		$fell(column_strobe_n) |-> !row_strobe_n && !$past(row_strobe_n);
	endproperty
	a_cas_after_ras: assert property (p_cas_after_ras) else $error("column before row"); // see (RL3)
	property p_addr_stable;
		@(posedge clock) disable iff (rst)
		$fell(column_strobe_n) |-> $stable(multiplexed_lines);
	endproperty
	a_addr_stable: assert property (p_addr_stable) else $error("address moved at strobe"); // see (RL2)
	property p_ewr_early;
		@(posedge clock) disable iff (rst)
		$fell(column_strobe_n) && op_r == OP_EWR |-> !store_select_n && !$past(store_select_n);
	endproperty
	a_ewr_early: assert property (p_ewr_early) else $error("early write select late"); // see (RL6)
	property p_read_high;
		@(posedge clock) disable iff (rst)
		!column_strobe_n && op_r == OP_READ |-> store_select_n;
	endproperty
	a_read_high: assert property (p_read_high) else $error("read with write select"); // see (RL4)
	property p_rsp_after;
		@(posedge clock) disable iff (rst)
		rd_r |-> !column_strobe_n ##1 rsp_valid;
	endproperty
	a_rsp_after: assert property (p_rsp_after) else $error("sample outside column low"); // see (RL10)
endmodule : drc_ctrl

// *** dv/drc_dram_model.sv ***
// Purpose: Behavioural 16K x 1 strobe memory facing the controller
// Assumes: Pins change only just after the clock's rising edge
// Notes:   Counters report strobe cycles, refresh coverage and misuse
`timescale 1ns/1ps
`include "drc_consts.svh"
module drc_dram_model #(
	parameter real RETAIN_NS = `DRC_T_REF_MS * 1.0e6
) (
	// Edge reference
	input  wire logic       clock,
	// Device pins
	input  wire logic       row_strobe_n,
	input  wire logic       column_strobe_n,
	input  wire logic       store_select_n,
	input  wire logic [6:0] multiplexed_lines,
	input  wire logic       input_bit,
	output logic            output_bit,
	// Observation
	output int              ras_cnt,
	output int              rows_done,
	output int              lost,
	output int              viol
);
	logic         mem [0:16383];
	logic [127:0] done_r = 128'h0;
	realtime      t_ref [0:127];
	realtime      t_ras = 0;
	realtime      t_cas = 0;
	logic [6:0]   a_pre, row, col;
	logic         w_pre, d_pre;
	logic         drv = 1'b0;
	logic         early = 1'b0;
	logic         cas_seen = 1'b0;
	initial begin
		ras_cnt = 0;
		rows_done = 0;
		lost = 0;
		viol = 0;
	end
	// Pin values held up to the edge
	always @(posedge clock) begin
		a_pre = multiplexed_lines;
		w_pre = store_select_n;
		d_pre = input_bit;
	end
	always @(negedge row_strobe_n) begin
		row = a_pre;
		t_ras = $realtime;
		cas_seen = 1'b0;
		ras_cnt++;
		t_ref[row] = $realtime;
		if (ras_cnt == `DRC_INIT_CYCLES)
			foreach (t_ref[i])
				t_ref[i] = $realtime;
	end
	always @(posedge row_strobe_n) begin
		if (!cas_seen)
			done_r[row] = 1'b1;
		rows_done = $countones(done_r);
	end
	always @(negedge column_strobe_n) begin
		if (row_strobe_n !== 1'b0 || ras_cnt < `DRC_INIT_CYCLES)
			viol++;
		col = a_pre;
		cas_seen = 1'b1;
		t_cas = $realtime;
		early = !w_pre;
		if (early)
			mem[{row, col}] = d_pre;
	end
	always @(negedge store_select_n)
		if (column_strobe_n === 1'b0 && !early)
			mem[{row, col}] = d_pre;
	// Drives only after both access delays, never in an early write
	always #5 drv = column_strobe_n === 1'b0 && !early && $realtime - t_cas >= `DRC_T_CAC_NS
		&& $realtime - t_ras >= `DRC_T_RAC_NS;
	// Unlatched; shows the inverse while floating
	assign output_bit = drv ? mem[{row, col}] : !mem[{row, col}];
	always #1000
		if (ras_cnt >= `DRC_INIT_CYCLES)
			foreach (t_ref[i])
				if ($realtime - t_ref[i] > RETAIN_NS) begin
					lost++;
					t_ref[i] = $realtime;
				end
endmodule : drc_dram_model

// *** dv/drc_ctrl_tb.sv ***
// Purpose: Self-checking bench for the strobe memory controller
// Assumes: Behavioural memory model on the far side
// Notes:   Refresh period shortened; retention scaled to match
`timescale 1ns/1ps
`include "drc_consts.svh"
module drc_ctrl_tb import drc_pkg::*; ;
	localparam int REF = 12800;
	localparam logic [13:0] ADRS [4] = '{14'h0000, 14'h3fff, 14'h2a55, 14'h0080};
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        req_valid = 1'b0;
	logic [13:0] req_addr = 14'h0;
	logic [1:0]  req_op = 2'h0;
	logic        req_wdata = 1'b0;
	logic        req_page = 1'b0;
	logic        req_ready, rsp_valid, rsp_rdata, init_done, input_bit, output_bit;
	logic        row_strobe_n, column_strobe_n, store_select_n;
	logic [6:0]  multiplexed_lines;
	int          ras_cnt, rows_done, lost, viol;
	int          fails = 0;
	int          check_count = 0;
	always #25 clock = ~clock;
	drc_ctrl #(.REF_CYCLES(REF)) i_dut (.clock(clock), .rst(rst), .req_valid(req_valid),
		.req_addr(req_addr), .req_op(req_op), .req_wdata(req_wdata), .req_page(req_page),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.init_done(init_done), .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
		.store_select_n(store_select_n), .multiplexed_lines(multiplexed_lines),
		.input_bit(input_bit), .output_bit(output_bit));
	// Slack covers one access delaying a refresh
	drc_dram_model #(.RETAIN_NS(REF * 50.0 + 2000.0)) i_mem (.clock(clock),
		.row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
		.store_select_n(store_select_n), .multiplexed_lines(multiplexed_lines),
		.input_bit(input_bit), .output_bit(output_bit), .ras_cnt(ras_cnt),
		.rows_done(rows_done), .lost(lost), .viol(viol));
	task finish_test;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task tick;
		@(posedge clock);
		#2;
	endtask : tick
	task bail;
		fails++;
		finish_test;
	endtask : bail
	task wait_ready;
		int n;
		for (n = 0; req_ready !== 1'b1; n++) begin
			tick;
			if (n > 500)
				bail;
		end
	endtask : wait_ready
	task wait_rsp;
		int n;
		for (n = 0; rsp_valid !== 1'b1; n++) begin
			tick;
			if (n > 50)
				bail;
		end
	endtask : wait_rsp
	task access(input logic [1:0] op, input logic [13:0] a, input logic d, input logic pg);
		req_op = op;
		req_addr = a;
		req_wdata = d;
		req_page = pg;
		req_valid = 1'b1;
		wait_ready;
		tick;
		req_valid = 1'b0;
		if (op == OP_EWR)
			repeat (2) tick;
		else
			wait_rsp;
	endtask : access
	task t_init;
		int n;
		repeat (8) tick;
		chk({row_strobe_n, column_strobe_n, store_select_n}, 3'h7);
		chk({req_ready, rsp_valid, init_done}, 3'h0);
		rst = 1'b0;
		for (n = 0; init_done !== 1'b1; n++) begin
			tick;
			if (n > 400)
				bail;
		end
		chk(ras_cnt >= `DRC_INIT_CYCLES, 1'b1);
		chk(viol, 0);
	endtask : t_init
	task t_rw;
		for (int i = 0; i < 4; i++)
			access(OP_EWR, ADRS[i], i[0], 1'b0);
		for (int i = 0; i < 4; i++) begin
			access(OP_READ, ADRS[i], !i[0], 1'b0);
			chk(rsp_rdata, i[0]);
		end
	endtask : t_rw
	task t_rmw;
		for (int v = 0; v < 2; v++) begin
			access(OP_EWR, 14'h1234, v[0], 1'b0);
			access(OP_RMW, 14'h1234, !v[0], 1'b0);
			chk(rsp_rdata, v[0]);
			access(OP_READ, 14'h1234, v[0], 1'b0);
			chk(rsp_rdata, !v[0]);
		end
	endtask : t_rmw
	task t_page;
		int n0;
		int n;
		access(OP_EWR, 14'h1500, 1'b1, 1'b0);
		access(OP_EWR, 14'h1501, 1'b0, 1'b0);
		n0 = ras_cnt;
		for (n = 0; ras_cnt == n0; n++) begin
			tick;
			if (n > 300)
				bail;
		end
		n0 = ras_cnt;
		req_op = OP_READ;
		req_addr = 14'h1500;
		req_page = 1'b1;
		req_valid = 1'b1;
		wait_ready;
		tick;
		// Same-row request waits for the page-hold cycle
		req_addr = 14'h1501;
		req_page = 1'b0;
		wait_rsp;
		chk(rsp_rdata, 1'b1);
		tick;
		wait_rsp;
		req_valid = 1'b0;
		chk(rsp_rdata, 1'b0);
		chk(ras_cnt - n0, 1);
	endtask : t_page
	task t_refresh;
		repeat (REF + 200) tick;
		chk(rows_done, 128);
		chk(lost, 0);
		chk(viol, 0);
		access(OP_READ, 14'h3fff, 1'b0, 1'b0);
		chk(rsp_rdata, 1'b1);
	endtask : t_refresh
	initial begin
		t_init;
		t_rw;
		t_rmw;
		t_page;
		t_refresh;
		finish_test;
	end
endmodule : drc_ctrl_tb
